// [hw/hpb_pkg.sv]
// Purpose: Shared constants for the host port buffer, request pin and bank interrupt.
// Assumes: On-chip CPU and external port both address the buffer in 32-bit words.
// Notes: CPU register offsets and external index codes are fixed here only.
package hpb_pkg;

	// ----------------------------------------------------------------
	// Buffer geometry
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 32;
	localparam int WADDR_BITS = 8;
	localparam int BANKS = 2;
	localparam int RAM_WORDS = 512;
	localparam logic [WADDR_BITS-1:0] FIRST_WORD = 8'h00;
	localparam logic [WADDR_BITS-1:0] LAST_WORD = 8'hFF;

	// ----------------------------------------------------------------
	// On-chip CPU address map
	// ----------------------------------------------------------------
	localparam logic [31:0] CPU_BUF_BASE = 32'hF84E_0000;
	localparam logic [31:0] CPU_REG_BOOT = 32'hF84F_0000;
	localparam logic [31:0] CPU_REG_TRIG = 32'hF84F_0004;
	localparam logic [31:0] CPU_REG_BIRQ = 32'hF84F_0008;
	localparam logic [2:0] BOOT_AREA_NONE = 3'b111;

	// ----------------------------------------------------------------
	// External index codes and field positions
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_ADDR = 6'h00;
	localparam logic [5:0] IDX_DATA = 6'h01;
	localparam logic [5:0] IDX_BOOT = 6'h02;
	localparam logic [7:0] LOCK_KEY = 8'hA5;
	localparam int LOCK_BIT = 0;
	localparam int TRIG_BIT = 0;
	localparam int BIRQ_FLAG_BIT = 0;
	localparam int BIRQ_EN_BIT = 1;
	localparam int ADDR_LSB = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [5:0] REQ_PULSE_CYCLES = 6'h20;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] INDEX_RESET = 6'h00;
	localparam logic [WORD_BITS-1:0] WORD_ZERO = 32'h0000_0000;

endpackage

// [hw/hpb_host_port_buffer.sv]
// Purpose: Shared buffer of a host port with CPU lockout, DMA request pin and bank interrupt.
// Assumes: Strobes, select and data arrive asynchronously and are held steady around edges.
// Notes: Lock, direction, step and bank controls come from the rest of the port as levels.
//
// Overview of operation
// - CPU buffer access stalls while lockout is set.
// - Lockout resets from boot strap; host clear releases.
// - Lockout concerns only the CPU-side bank.
// - CPU trigger write raises shaped DMA request.
// - Trigger self-clears on negation; zero writes ignored.
// - Bank interrupt equals flag and enable.
// - Incrementing: flag after last word, select negated.
// - Decrementing: flag after first word, select negated.
// - CPU clears flag by zero; one ignored.
// - External side sees each bank at 0-3FF.
// - CPU sees its bank at F84E0000-F84E03FF.
// - Boot mode forces bank 0, maps area windows.
// - Read or write is strobe and select overlap.
// - Select input picks index/status or normal access.
// - Level, low polarity: low until select pair low.
// - Level, high polarity: idle low, high until pair.
// - Edge, low polarity: 32-cycle low pulse.
// - Edge, high polarity: idle low, 32-cycle high pulse.
// - Consecutive access steps address by one word (four bytes).
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Small ring buffer with valid and ready on both sides
// ----------------------------------------------------------------
module hpb_fifo
#(
	parameter int WIDTH = 33,
	parameter int DEPTH = 2
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [PW:0] COUNT_FULL = (PW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wrPtr_q;
	logic [PW-1:0] rdPtr_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;

	assign inReady = (count_q != COUNT_FULL);
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdPtr_q];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_q[wrPtr_q] <= inData;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else if (flush)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// ----------------------------------------------------------------
// Host port buffer top
// ----------------------------------------------------------------
module hpb_host_port_buffer
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic bootModeStrap,
	input wire logic portSelectN,
	input wire logic portReadStrobeN,
	input wire logic portWriteStrobeN,
	input wire logic indexOrNormalSel,
	input wire logic [hpb_pkg::WORD_BITS-1:0] portDataIn,
	output logic [hpb_pkg::WORD_BITS-1:0] portDataOut,
	output logic portDataOe,
	output logic dmaRequestPin,
	output logic bankIrq,
	input wire logic bankSchemeSel,
	input wire logic bankPick,
	input wire logic lockHold,
	input wire logic readDir,
	input wire logic writeDir,
	input wire logic addrStepDir,
	input wire logic requestShapeSel,
	input wire logic requestLevelSel,
	input wire logic cpuReq,
	input wire logic cpuWe,
	input wire logic [31:0] cpuAddr,
	input wire logic [hpb_pkg::WORD_BITS-1:0] cpuWdata,
	output logic [hpb_pkg::WORD_BITS-1:0] cpuRdata,
	output logic cpuAck
);
	import hpb_pkg::*;

	logic [4:0] pinMeta_q;
	logic [4:0] pinSync_q;
	logic [WORD_BITS-1:0] dataMeta_q;
	logic [WORD_BITS-1:0] dataSync_q;
	logic csS, rdS, wrS, rsS, strapS;
	logic rdAct, wrAct, rdAct_q, wrAct_q;
	logic rdStart, rdEnd, wrEnd;
	logic rsLat_q;
	logic [WORD_BITS-1:0] wrData_q;
	logic [5:0] index_q;
	logic [WADDR_BITS-1:0] addrWord_q;
	logic [WORD_BITS-1:0] dataWin_q;
	logic [WORD_BITS-1:0] sharedBuf [RAM_WORDS];
	logic bootMode_q, acLock_q;
	logic [1:0] strapCnt_q;
	logic strapDone_q;
	logic trigger_q;
	logic [5:0] pulseCnt_q;
	logic birqFlag_q, birqEn_q, endPending_q, prefetchDone_q;
	logic extBank, cpuBank;
	logic [8:0] extIdx, cpuIdx;
	logic stepNext;
	logic [WADDR_BITS-1:0] addrStep;
	logic atEnd, consRead, consWrite;
	logic cpuBufHit, cpuGo, cpuStall;
	logic extDataWr, addrWr, rdPop;
	logic fillValid, fillReady, headValid;
	logic [WORD_BITS:0] headData;
	logic reqNegate, trigSet, flagSet;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinMeta_q <= 5'h1F;
			pinSync_q <= 5'h1F;
			dataMeta_q <= WORD_ZERO;
			dataSync_q <= WORD_ZERO;
		end
		else
		begin
			pinMeta_q <= {bootModeStrap, portSelectN, portReadStrobeN, portWriteStrobeN,
				indexOrNormalSel};
			pinSync_q <= pinMeta_q;
			dataMeta_q <= portDataIn;
			dataSync_q <= dataMeta_q;
		end
	end

	assign {strapS, csS, rdS, wrS, rsS} = pinSync_q;
	assign rdAct = ~csS & ~rdS;
	assign wrAct = ~csS & ~wrS;
	assign rdStart = rdAct & ~rdAct_q;
	assign rdEnd = ~rdAct & rdAct_q;
	assign wrEnd = ~wrAct & wrAct_q;

	// Select level and write data are taken while the strobe overlap lasts, so the
	// commit at the trailing edge uses values the host held during the access.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdAct_q <= 1'b0;
			wrAct_q <= 1'b0;
			rsLat_q <= 1'b0;
			wrData_q <= WORD_ZERO;
		end
		else
		begin
			rdAct_q <= rdAct;
			wrAct_q <= wrAct;
			if (rdAct || wrAct)
				rsLat_q <= rsS;
			if (wrAct)
				wrData_q <= dataSync_q;
		end
	end

	// ----------------------------------------------------------------
	// Bank mapping and address stepping
	// ----------------------------------------------------------------
	assign extBank = bootMode_q ? 1'b0 : (bankSchemeSel & bankPick);
	assign cpuBank = bootMode_q ? 1'b0 : (bankSchemeSel & ~bankPick);
	assign extIdx = {extBank, addrWord_q};
	assign cpuIdx = {cpuBank, cpuAddr[9:2]};
	assign addrStep = addrStepDir ? addrWord_q - 1'b1 : addrWord_q + 1'b1;
	assign atEnd = addrStepDir ? (addrWord_q == FIRST_WORD) : (addrWord_q == LAST_WORD);
	assign consRead = lockHold & readDir;
	assign consWrite = lockHold & writeDir;

	assign addrWr = wrEnd & ~rsLat_q & (index_q == IDX_ADDR);
	assign extDataWr = wrEnd & ~rsLat_q & (index_q == IDX_DATA);
	assign rdPop = rdEnd & ~rsLat_q & (index_q == IDX_DATA) & consRead & headValid;
	assign fillValid = consRead & ~prefetchDone_q & ~addrWr;
	assign stepNext = (fillValid & fillReady) | (extDataWr & consWrite);

	// ----------------------------------------------------------------
	// Read-ahead buffer for consecutive reads
	// ----------------------------------------------------------------
	// Two words are fetched ahead so a host reading back to back never waits on
	// the buffer; the fetch stalls when the host stops reading.
	hpb_fifo #(.WIDTH(WORD_BITS + 1), .DEPTH(2)) readAhead
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.flush(addrWr | ~consRead),
		.inValid(fillValid),
		.inReady(fillReady),
		.inData({atEnd, sharedBuf[extIdx]}),
		.outValid(headValid),
		.outReady(rdPop),
		.outData(headData)
	);

	// ----------------------------------------------------------------
	// External registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			index_q <= INDEX_RESET;
			addrWord_q <= FIRST_WORD;
			dataWin_q <= WORD_ZERO;
			prefetchDone_q <= 1'b0;
		end
		else
		begin
			if (wrEnd && rsLat_q)
				index_q <= wrData_q[5:0];
			if (extDataWr)
				dataWin_q <= wrData_q;
			if (addrWr)
				addrWord_q <= wrData_q[9:ADDR_LSB];
			else if (stepNext)
				addrWord_q <= addrStep;
			if (addrWr || !consRead)
				prefetchDone_q <= 1'b0;
			else if (fillValid && fillReady && atEnd)
				prefetchDone_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (extDataWr && consWrite)
			sharedBuf[extIdx] <= wrData_q;
		if (cpuGo && cpuBufHit && cpuWe)
			sharedBuf[cpuIdx] <= cpuWdata;
	end

	// Read data is fixed at the leading edge of the overlap and held until the next read.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			portDataOut <= WORD_ZERO;
			portDataOe <= 1'b0;
		end
		else
		begin
			portDataOe <= rdAct;
			if (rdStart)
			begin
				if (rsS)
					portDataOut <= {29'h0, birqFlag_q, acLock_q, headValid};
				else
				begin
					unique case (index_q)
						IDX_ADDR: portDataOut <= {22'h0, addrWord_q, 2'b00};
						IDX_DATA: portDataOut <= (consRead && headValid) ?
							headData[WORD_BITS-1:0] : dataWin_q;
						IDX_BOOT: portDataOut <= {31'h0, acLock_q};
						default: portDataOut <= WORD_ZERO;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Boot strap and CPU lockout
	// ----------------------------------------------------------------
	// Lockout starts set so the CPU cannot touch the buffer before the strap settles.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strapCnt_q <= 2'h0;
			strapDone_q <= 1'b0;
			bootMode_q <= 1'b0;
			acLock_q <= 1'b1;
		end
		else if (!strapDone_q)
		begin
			// The strap flops still show their reset level for two edges, so the
			// capture waits until the whole settle count has elapsed.
			if (strapCnt_q != STRAP_SETTLE)
				strapCnt_q <= strapCnt_q + 1'b1;
			else
			begin
				strapDone_q <= 1'b1;
				bootMode_q <= strapS;
				acLock_q <= strapS;
			end
		end
		else if (wrEnd && !rsLat_q && index_q == IDX_BOOT)
		begin
			if (wrData_q[7:0] == LOCK_KEY)
				acLock_q <= 1'b1;
			else if (!wrData_q[LOCK_BIT])
				acLock_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// CPU side access
	// ----------------------------------------------------------------
	assign cpuBufHit = (cpuAddr[31:10] == CPU_BUF_BASE[31:10]) | (bootMode_q &
		(cpuAddr[31:29] != BOOT_AREA_NONE) & (cpuAddr[28:10] == 19'h0));
	assign cpuStall = cpuBufHit & acLock_q;
	assign cpuGo = cpuReq & ~cpuAck & ~cpuStall;
	assign trigSet = cpuGo & cpuWe & (cpuAddr == CPU_REG_TRIG) & cpuWdata[TRIG_BIT];

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cpuAck <= 1'b0;
			cpuRdata <= WORD_ZERO;
		end
		else
		begin
			cpuAck <= cpuGo;
			if (cpuGo)
			begin
				if (cpuBufHit)
					cpuRdata <= sharedBuf[cpuIdx];
				else if (cpuAddr == CPU_REG_BOOT)
					cpuRdata <= {31'h0, acLock_q};
				else if (cpuAddr == CPU_REG_TRIG)
					cpuRdata <= {31'h0, trigger_q};
				else if (cpuAddr == CPU_REG_BIRQ)
					cpuRdata <= {30'h0, birqEn_q, birqFlag_q};
				else
					cpuRdata <= WORD_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// DMA request pin
	// ----------------------------------------------------------------
	assign reqNegate = trigger_q & (requestShapeSel ?
		(pulseCnt_q == REQ_PULSE_CYCLES - 1'b1) : (~csS & ~rsS));

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trigger_q <= 1'b0;
			pulseCnt_q <= 6'h0;
			dmaRequestPin <= 1'b1;
		end
		else
		begin
			if (trigSet && !trigger_q)
			begin
				trigger_q <= 1'b1;
				pulseCnt_q <= 6'h0;
			end
			else if (reqNegate)
				trigger_q <= 1'b0;
			else if (trigger_q)
				pulseCnt_q <= pulseCnt_q + 1'b1;
			// The high polarity pulse is driven high since its idle level is low.
			dmaRequestPin <= requestLevelSel ? trigger_q : ~trigger_q;
		end
	end

	// ----------------------------------------------------------------
	// Bank interrupt
	// ----------------------------------------------------------------
	assign flagSet = endPending_q & csS;

	// The flag waits for select to rise, so a host still inside its last cycle
	// does not see the bank swapped underneath it.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			endPending_q <= 1'b0;
			birqFlag_q <= 1'b0;
			birqEn_q <= 1'b0;
			bankIrq <= 1'b0;
		end
		else
		begin
			if ((extDataWr && consWrite && atEnd) || (rdPop && headData[WORD_BITS]))
				endPending_q <= 1'b1;
			else if (flagSet)
				endPending_q <= 1'b0;
			if (cpuGo && cpuWe && cpuAddr == CPU_REG_BIRQ)
				birqEn_q <= cpuWdata[BIRQ_EN_BIT];
			if (flagSet)
				birqFlag_q <= 1'b1;
			else if (cpuGo && cpuWe && cpuAddr == CPU_REG_BIRQ && !cpuWdata[BIRQ_FLAG_BIT])
				birqFlag_q <= 1'b0;
			bankIrq <= birqFlag_q & birqEn_q;
		end
	end
endmodule

// [bench/hpb_host_model.sv]
// Purpose: External host that drives the port strobes.
// Assumes: Pins change on falling clock edges.
// Notes: Released data lines carry the inverse of the last word.
`timescale 1ns/1ps
module hpb_host_model
(
	input wire logic ref_clk,
	output logic selN,
	output logic rdN,
	output logic wrN,
	output logic rs,
	output logic [31:0] wdata,
	input wire logic [31:0] rdata
);
	initial
	begin
		selN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		rs = 1'b0;
		wdata = 32'h0000_0000;
	end
	// Strobes stay low five and high four clocks, above the three-clock minimum.
	task automatic acc(input bit wr, input bit sel, input logic [31:0] d,
		output logic [31:0] q);
	begin
		@(negedge ref_clk);
		rs = sel;
		wdata = d;
		selN = 1'b0;
		rdN = wr;
		wrN = !wr;
		repeat (5) @(negedge ref_clk);
		q = rdata;
		selN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		wdata = ~d;
		repeat (4) @(negedge ref_clk);
	end
	endtask
	task automatic reg_acc(input bit wr, input logic [5:0] idx, input logic [31:0] d,
		output logic [31:0] q);
	begin
		acc(1'b1, 1'b1, {26'h000_0000, idx}, q);
		acc(wr, 1'b0, d, q);
	end
	endtask
endmodule

// [bench/hpb_host_port_buffer_checker.sv]
// Purpose: Concurrent checks on the host port buffer ports.
// Assumes: One clock domain with active-low reset.
// Notes: Short histories cover the pin synchroniser latency.
`timescale 1ns/1ps
module hpb_host_port_buffer_checker
import hpb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic portSelectN,
	input wire logic portReadStrobeN,
	input wire logic indexOrNormalSel,
	input wire logic portDataOe,
	input wire logic dmaRequestPin,
	input wire logic bankIrq,
	input wire logic requestShapeSel,
	input wire logic requestLevelSel,
	input wire logic cpuReq,
	input wire logic cpuWe,
	input wire logic [31:0] cpuAddr,
	input wire logic cpuAck
);
	logic act;
	logic levelQ_q;
	logic selPrev_q;
	logic [6:0] actCnt_q;
	logic [5:0] pairHist_q, rdHist_q, selHiHist_q, birqHist_q, trigHist_q;
	// Polarity is taken one clock late because the pin follows it through a flop.
	assign act = levelQ_q ? dmaRequestPin : !dmaRequestPin;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			levelQ_q <= 1'b0;
			selPrev_q <= 1'b1;
			actCnt_q <= 7'h00;
			pairHist_q <= 6'h00;
			rdHist_q <= 6'h00;
			selHiHist_q <= 6'h00;
			birqHist_q <= 6'h00;
			trigHist_q <= 6'h00;
		end
		else
		begin
			levelQ_q <= requestLevelSel;
			actCnt_q <= act ? actCnt_q + 7'h01 : 7'h00;
			pairHist_q <= {pairHist_q[4:0], !portSelectN && !indexOrNormalSel};
			rdHist_q <= {rdHist_q[4:0], !portSelectN && !portReadStrobeN};
			selPrev_q <= portSelectN;
			selHiHist_q <= {selHiHist_q[4:0], portSelectN && !selPrev_q};
			birqHist_q <= {birqHist_q[4:0], cpuReq && cpuWe && cpuAddr == CPU_REG_BIRQ};
			trigHist_q <= {trigHist_q[4:0], cpuReq && cpuWe && cpuAddr == CPU_REG_TRIG};
		end
	end
	a_pulse_length:
	assert property (requestShapeSel && $past(act) && !act |-> actCnt_q == {1'b0, REQ_PULSE_CYCLES})
		else $error("request pulse length wrong");
	a_level_until_pair:
	assert property (!requestShapeSel && $past(act) && !act |-> |pairHist_q)
		else $error("level request dropped without select pair");
	a_request_cause:
	assert property (!$past(act) && act |-> |trigHist_q)
		else $error("request raised without trigger write");
	a_irq_rise_cause:
	assert property ($rose(bankIrq) |-> |selHiHist_q || |birqHist_q)
		else $error("bank interrupt rose without cause");
	a_irq_fall_cause:
	assert property ($fell(bankIrq) |-> |birqHist_q)
		else $error("bank interrupt fell without cpu write");
	a_oe_after_read:
	assert property (portDataOe |-> |rdHist_q)
		else $error("data driven without read overlap");
	a_ack_one_cycle:
	assert property (cpuAck |=> !cpuAck)
		else $error("ack longer than one cycle");
	a_ack_needs_req:
	assert property (cpuAck |-> $past(cpuReq))
		else $error("ack without request");
endmodule
bind hpb_host_port_buffer hpb_host_port_buffer_checker hpb_host_port_buffer_checker_inst (
	.ref_clk(ref_clk), .resetn(resetn), .portSelectN(portSelectN),
	.portReadStrobeN(portReadStrobeN), .indexOrNormalSel(indexOrNormalSel),
	.portDataOe(portDataOe), .dmaRequestPin(dmaRequestPin), .bankIrq(bankIrq),
	.requestShapeSel(requestShapeSel), .requestLevelSel(requestLevelSel),
	.cpuReq(cpuReq), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuAck(cpuAck));

// [bench/hpb_host_port_buffer_bench.sv]
// Purpose: Self-checking bench for the host port buffer.
// Assumes: Inputs change on falling clock edges.
// Notes: Random data words come from a fixed seed.
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		samplesChecked++; \
		if ((got) !== (exp)) \
		begin \
			badCount++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module hpb_host_port_buffer_bench;
	import hpb_pkg::*;
	logic ref_clk, resetn, bootModeStrap, bankSchemeSel, bankPick, lockHold;
	logic readDir, writeDir, addrStepDir, requestShapeSel, requestLevelSel;
	logic cpuReq, cpuWe, cpuAck, portDataOe, dmaRequestPin, bankIrq;
	logic portSelectN, portReadStrobeN, portWriteStrobeN, indexOrNormalSel;
	logic [31:0] cpuAddr, cpuWdata, cpuRdata, portDataIn, portDataOut, q, d;
	logic [31:0] w [4];
	integer seed;
	int badCount, samplesChecked, ackCount, base, n, i, m;
	hpb_host_port_buffer hpb_host_port_buffer_inst (.ref_clk(ref_clk), .resetn(resetn),
		.bootModeStrap(bootModeStrap), .portSelectN(portSelectN),
		.portReadStrobeN(portReadStrobeN), .portWriteStrobeN(portWriteStrobeN),
		.indexOrNormalSel(indexOrNormalSel), .portDataIn(portDataIn),
		.portDataOut(portDataOut), .portDataOe(portDataOe), .dmaRequestPin(dmaRequestPin),
		.bankIrq(bankIrq), .bankSchemeSel(bankSchemeSel), .bankPick(bankPick),
		.lockHold(lockHold), .readDir(readDir), .writeDir(writeDir),
		.addrStepDir(addrStepDir), .requestShapeSel(requestShapeSel),
		.requestLevelSel(requestLevelSel), .cpuReq(cpuReq), .cpuWe(cpuWe),
		.cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuAck(cpuAck));
	hpb_host_model hpb_host_model_inst (.ref_clk(ref_clk), .selN(portSelectN),
		.rdN(portReadStrobeN), .wrN(portWriteStrobeN), .rs(indexOrNormalSel),
		.wdata(portDataIn), .rdata(portDataOut));
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (cpuAck === 1'b1) ackCount++;
	task automatic tallyAndFinish;
	begin
		$display("checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task automatic cpu(input bit we, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
	begin
		@(negedge ref_clk);
		cpuReq = 1'b1;
		cpuWe = we;
		cpuAddr = a;
		cpuWdata = wd;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		while (cpuAck !== 1'b1 && k < 300);
		rd = cpuRdata;
		@(negedge ref_clk);
		cpuReq = 1'b0;
		if (k >= 300)
		begin
			badCount++;
			tallyAndFinish();
		end
	end
	endtask
	task automatic doReset(input bit strap);
	begin
		resetn = 1'b0;
		bootModeStrap = strap;
		repeat (16) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
	end
	endtask
	initial
	begin
		seed = 32'h3285_7917;
		{bankSchemeSel, bankPick, lockHold, readDir, writeDir, addrStepDir} = 6'h00;
		{requestShapeSel, requestLevelSel, cpuReq, cpuWe} = 4'h0;
		cpuAddr = 32'h0000_0000;
		cpuWdata = 32'h0000_0000;
		doReset(1'b0);
		`CHECK(dmaRequestPin, 1'b1);
		cpu(0, CPU_REG_BOOT, 0, q);
		`CHECK(q, WORD_ZERO);
		cpu(1, CPU_REG_BIRQ, 32'hFFFF_FFFC, q);
		cpu(0, CPU_REG_BIRQ, 0, q);
		`CHECK(q, WORD_ZERO);
		cpu(0, 32'h1234_0000, 0, q);
		`CHECK(q, WORD_ZERO);
		$display("registers done");
		for (i = 0; i < 4; i++)
		begin
			w[i] = $random(seed);
			cpu(1, CPU_BUF_BASE + 32'h0000_03F0 + 4 * i, w[i], q);
		end
		cpu(1, CPU_REG_BIRQ, 32'h0000_0002, q);
		{lockHold, readDir} = 2'b11;
		hpb_host_model_inst.reg_acc(1'b1, IDX_ADDR, 32'h0000_03F0, q);
		hpb_host_model_inst.reg_acc(1'b0, IDX_DATA, 0, q);
		`CHECK(q, w[0]);
		for (i = 1; i < 4; i++)
		begin
			hpb_host_model_inst.acc(1'b0, 1'b0, 0, q);
			`CHECK(q, w[i]);
		end
		repeat (3) @(negedge ref_clk);
		`CHECK(bankIrq, 1'b1);
		cpu(1, CPU_REG_BIRQ, 32'h0000_0001, q);
		@(negedge ref_clk);
		`CHECK(bankIrq, 1'b0);
		cpu(1, CPU_REG_BIRQ, 32'h0000_0003, q);
		@(negedge ref_clk);
		`CHECK(bankIrq, 1'b1);
		cpu(1, CPU_REG_BIRQ, 32'h0000_0002, q);
		@(negedge ref_clk);
		`CHECK(bankIrq, 1'b0);
		cpu(1, CPU_REG_BIRQ, 32'h0000_0003, q);
		@(negedge ref_clk);
		`CHECK(bankIrq, 1'b0);
		$display("consecutive read done");
		{lockHold, readDir, writeDir, addrStepDir} = 4'b1011;
		hpb_host_model_inst.reg_acc(1'b1, IDX_ADDR, 32'h0000_0004, q);
		hpb_host_model_inst.reg_acc(1'b1, IDX_DATA, w[3], q);
		hpb_host_model_inst.acc(1'b1, 1'b0, w[2], q);
		repeat (3) @(negedge ref_clk);
		`CHECK(bankIrq, 1'b1);
		cpu(0, CPU_BUF_BASE + 32'h0000_0004, 0, q);
		`CHECK(q, w[3]);
		cpu(0, CPU_BUF_BASE, 0, q);
		`CHECK(q, w[2]);
		bankSchemeSel = 1'b1;
		d = $random(seed);
		cpu(1, CPU_BUF_BASE + 32'h0000_0004, d, q);
		bankPick = 1'b1;
		cpu(0, CPU_BUF_BASE + 32'h0000_0004, 0, q);
		`CHECK(q, w[3]);
		bankPick = 1'b0;
		cpu(0, CPU_BUF_BASE + 32'h0000_0004, 0, q);
		`CHECK(q, d);
		bankSchemeSel = 1'b0;
		{lockHold, writeDir, addrStepDir} = 3'b000;
		cpu(1, CPU_REG_BIRQ, 32'h0000_0000, q);
		$display("consecutive write done");
		// Every shape and polarity pair, counting active cycles from the trigger.
		for (m = 0; m < 4; m++)
		begin
			requestShapeSel = m[1];
			requestLevelSel = m[0];
			repeat (3) @(negedge ref_clk);
			`CHECK(dmaRequestPin, !m[0]);
			cpu(0, CPU_REG_TRIG, 0, q);
			`CHECK(q, WORD_ZERO);
			cpu(1, CPU_REG_TRIG, 32'h0000_0001, q);
			n = 0;
			repeat (60) @(negedge ref_clk) if (dmaRequestPin === m[0]) n++;
			`CHECK(n, m[1] ? 32 : 60);
			cpu(1, CPU_REG_TRIG, 0, q);
			cpu(0, CPU_REG_TRIG, 0, q);
			`CHECK(q, m[1] ? WORD_ZERO : 32'h0000_0001);
			hpb_host_model_inst.reg_acc(1'b0, IDX_DATA, 0, q);
			repeat (3) @(negedge ref_clk);
			`CHECK(dmaRequestPin, !m[0]);
			cpu(0, CPU_REG_TRIG, 0, q);
			`CHECK(q, WORD_ZERO);
		end
		$display("request pin done");
		doReset(1'b1);
		cpu(0, CPU_REG_BOOT, 0, q);
		`CHECK(q, 32'h0000_0001);
		d = $random(seed);
		@(negedge ref_clk);
		base = ackCount;
		fork
			cpu(1, 32'hA000_0010, d, w[0]);
			begin
				repeat (20) @(negedge ref_clk);
				`CHECK(ackCount, base);
				hpb_host_model_inst.reg_acc(1'b1, IDX_BOOT, WORD_ZERO, q);
			end
		join
		cpu(0, CPU_BUF_BASE + 32'h0000_0010, 0, q);
		`CHECK(q, d);
		hpb_host_model_inst.reg_acc(1'b1, IDX_BOOT, 32'h0000_0001, q);
		cpu(0, CPU_REG_BOOT, 0, q);
		`CHECK(q, WORD_ZERO);
		hpb_host_model_inst.reg_acc(1'b1, IDX_BOOT, 32'h0000_00A5, q);
		cpu(0, CPU_REG_BOOT, 0, q);
		`CHECK(q, 32'h0000_0001);
		$display("boot lockout done");
		tallyAndFinish();
	end
endmodule
